/* common/dlwb_pkg.sv */
// package: register map, field layout, reset values and states of the limit warning and bypass block
package dlwb_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] DLWB_OFS_CTRL = 8'h00;
  localparam logic [7:0] DLWB_OFS_CUR_LO = 8'h04;
  localparam logic [7:0] DLWB_OFS_CUR_HI = 8'h08;
  localparam logic [7:0] DLWB_OFS_CUR_MAX = 8'h0C;
  localparam logic [7:0] DLWB_OFS_FRQ_LO = 8'h10;
  localparam logic [7:0] DLWB_OFS_FRQ_HI = 8'h14;
  localparam logic [7:0] DLWB_OFS_FB_LO = 8'h18;
  localparam logic [7:0] DLWB_OFS_FB_HI = 8'h1C;
  localparam logic [7:0] DLWB_OFS_SKIP_BW = 8'h20;
  localparam logic [7:0] DLWB_OFS_SKIP_ONE = 8'h24;
  localparam logic [7:0] DLWB_OFS_SKIP_TWO = 8'h28;
  localparam logic [7:0] DLWB_OFS_ROUTE_SIG = 8'h2C;
  localparam logic [7:0] DLWB_OFS_ROUTE_REL = 8'h30;
  localparam logic [7:0] DLWB_OFS_WARN = 8'h34;
  localparam logic [7:0] DLWB_OFS_IRQ_STAT = 8'h38;
  localparam logic [7:0] DLWB_OFS_IRQ_CLR = 8'h3C;
  localparam logic [7:0] DLWB_OFS_IRQ_EN = 8'h40;
  localparam logic [7:0] DLWB_OFS_REF_ADJ = 8'h44;
  // ==========================================================================
  // field layout
  localparam int DLWB_CTRL_RANGE_BIT = 0;
  localparam int DLWB_NUM_WARN = 6;
  localparam int DLWB_W_CUR_LO = 0;
  localparam int DLWB_W_CUR_HI = 1;
  localparam int DLWB_W_FRQ_LO = 2;
  localparam int DLWB_W_FRQ_HI = 3;
  localparam int DLWB_W_FB_LO = 4;
  localparam int DLWB_W_FB_HI = 5;
  localparam int DLWB_WARN_ACTIVE_BIT = 6;
  // ==========================================================================
  // limits and reset values; current in 0.1 A, frequency in 0.1 Hz, feedback in 0.001 units
  localparam logic [15:0] DLWB_RST_CUR_LO = 16'h0000;
  localparam logic [15:0] DLWB_RST_CUR_MAX = 16'h00A0;
  localparam logic [15:0] DLWB_RST_FRQ_LO = 16'h0000;
  localparam logic [15:0] DLWB_RST_FRQ_HI = 16'h0528;
  localparam logic [15:0] DLWB_FRQ_MAX_LOW_RANGE = 16'h0528;
  localparam logic [15:0] DLWB_FRQ_MAX_HIGH_RANGE = 16'h2710;
  localparam logic signed [31:0] DLWB_RST_FB_LO = 32'hFFC2_F700;
  localparam logic signed [31:0] DLWB_RST_FB_HI = 32'h003D_0900;
  localparam logic signed [31:0] DLWB_FB_FLOOR = 32'hFA0A_1F00;
  localparam logic signed [31:0] DLWB_FB_CEIL = 32'h05F5_E100;
  localparam logic [15:0] DLWB_SKIP_BW_MAX = 16'h03E8;
  localparam logic [15:0] DLWB_SKIP_PT_MAX = 16'h2710;
  localparam logic [15:0] DLWB_RST_SKIP = 16'h0000;
  localparam logic [5:0] DLWB_RST_ROUTE = 6'h00;
  // ==========================================================================
  // supervision states
  typedef enum logic [1:0] {
    DLWB_ST_STOPPED = 2'b00,
    DLWB_ST_RAMPING = 2'b01,
    DLWB_ST_ACTIVE = 2'b10
  } dlwb_state_t;
endpackage : dlwb_pkg

/* logic/dlwb_limit_cmp.sv */
// module: registered low/high window comparison of one signed quantity
`timescale 1ns/1ps
`default_nettype none
module dlwb_limit_cmp (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // value and limits
  input wire logic signed [32:0] i_value,
  input wire logic signed [32:0] i_low,
  input wire logic signed [32:0] i_high,
  // results
  output logic o_below,
  output logic o_above
);
  logic below_reg;
  logic below_next;
  logic above_reg;
  logic above_next;
  always_comb begin
    below_next = (i_value < i_low);
    above_next = (i_value > i_high);
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      below_reg <= 1'b0;
      above_reg <= 1'b0;
    end else begin
      below_reg <= below_next;
      above_reg <= above_next;
    end
  end
  assign o_below = below_reg;
  assign o_above = above_reg;
endmodule : dlwb_limit_cmp
`default_nettype wire

/* logic/dlwb_skip_band.sv */
// module: moves a frequency reference out of a skip band to its nearest edge
`timescale 1ns/1ps
`default_nettype none
module dlwb_skip_band (
  // band setup
  input wire logic [15:0] i_width,
  input wire logic [15:0] i_point,
  // reference
  input wire logic [15:0] i_ref,
  output logic [15:0] o_ref
);
  logic [16:0] half;
  logic [16:0] lo_edge;
  logic [16:0] hi_edge;
  always_comb begin
    // band reaches half the width on each side of the point
    half = {2'b00, i_width[15:1]};
    lo_edge = ({1'b0, i_point} > half) ? ({1'b0, i_point} - half) : 17'h0_0000;
    hi_edge = {1'b0, i_point} + half;
    o_ref = i_ref;
    if ((i_width != 16'h0000) && ({1'b0, i_ref} > lo_edge) && ({1'b0, i_ref} < hi_edge)) begin
      if (i_ref < i_point) begin
        o_ref = lo_edge[15:0];
      end else begin
        o_ref = hi_edge[15:0];
      end
    end
  end
endmodule : dlwb_skip_band
`default_nettype wire

/* logic/dlwb_top.sv */
// module: limit warnings with start/stop blocking, warning routing, frequency skip bands, Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
module dlwb_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // drive measurements and commands
  input wire logic i_run,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_out_freq,
  input wire logic signed [31:0] i_feedback,
  input wire logic [15:0] i_ref_freq,
  // outputs
  output logic [15:0] o_ref_adjusted,
  output logic o_signal_warn,
  output logic o_relay_warn,
  output logic o_irq
);
  import dlwb_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [15:0] umin16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : umin16

  function automatic logic signed [31:0] smin32(input logic signed [31:0] a, input logic signed [31:0] b);
    return (a < b) ? a : b;
  endfunction : smin32

  // ==========================================================================
  // register state
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic range_reg;
  logic range_next;
  logic [15:0] cur_lo_reg;
  logic [15:0] cur_lo_next;
  logic [15:0] cur_hi_reg;
  logic [15:0] cur_hi_next;
  logic [15:0] cur_max_reg;
  logic [15:0] cur_max_next;
  logic [15:0] frq_lo_reg;
  logic [15:0] frq_lo_next;
  logic [15:0] frq_hi_reg;
  logic [15:0] frq_hi_next;
  logic signed [31:0] fb_lo_reg;
  logic signed [31:0] fb_lo_next;
  logic signed [31:0] fb_hi_reg;
  logic signed [31:0] fb_hi_next;
  logic [15:0] skip_bw_reg;
  logic [15:0] skip_bw_next;
  logic [15:0] skip_one_reg;
  logic [15:0] skip_one_next;
  logic [15:0] skip_two_reg;
  logic [15:0] skip_two_next;
  logic [5:0] route_sig_reg;
  logic [5:0] route_sig_next;
  logic [5:0] route_rel_reg;
  logic [5:0] route_rel_next;
  logic [5:0] irq_stat_reg;
  logic [5:0] irq_stat_next;
  logic [5:0] irq_en_reg;
  logic [5:0] irq_en_next;

  logic access;
  logic do_write;
  logic [31:0] wv;
  logic [15:0] frq_top;
  logic signed [31:0] fb_w;

  // ==========================================================================
  // supervision and warning state
  dlwb_state_t state_reg;
  dlwb_state_t state_next;
  logic run_d_reg;
  logic [5:0] warn_reg;
  logic [5:0] warn_next;
  logic [5:0] warn_d_reg;
  logic sig_reg;
  logic sig_next;
  logic rel_reg;
  logic rel_next;
  logic irq_reg;
  logic irq_next;
  logic [15:0] ref_adj_reg;
  logic [15:0] ref_mid;
  logic [15:0] ref_fin;
  logic [5:0] cmp_raw;
  logic signed [32:0] cmp_val [3];
  logic signed [32:0] cmp_lo [3];
  logic signed [32:0] cmp_hi [3];

  // ==========================================================================
  // comparators: current, frequency, feedback
  always_comb begin
    cmp_val[0] = {17'h0_0000, i_out_current};
    cmp_lo[0] = {17'h0_0000, cur_lo_reg};
    cmp_hi[0] = {17'h0_0000, cur_hi_reg};
    cmp_val[1] = {17'h0_0000, i_out_freq};
    cmp_lo[1] = {17'h0_0000, frq_lo_reg};
    cmp_hi[1] = {17'h0_0000, frq_hi_reg};
    cmp_val[2] = {i_feedback[31], i_feedback};
    cmp_lo[2] = {fb_lo_reg[31], fb_lo_reg};
    cmp_hi[2] = {fb_hi_reg[31], fb_hi_reg};
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_cmp
      // each pair of warnings shares one comparator stage
      dlwb_limit_cmp u_cmp (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_value(cmp_val[g]),
        .i_low(cmp_lo[g]),
        .i_high(cmp_hi[g]),
        .o_below(cmp_raw[2*g]),
        .o_above(cmp_raw[2*g+1])
      );
    end
  endgenerate

  // ==========================================================================
  // skip bands applied one after the other
  dlwb_skip_band u_skip_one (
    .i_width(skip_bw_reg),
    .i_point(skip_one_reg),
    .i_ref(i_ref_freq),
    .o_ref(ref_mid)
  );

  dlwb_skip_band u_skip_two (
    .i_width(skip_bw_reg),
    .i_point(skip_two_reg),
    .i_ref(ref_mid),
    .o_ref(ref_fin)
  );

  // ==========================================================================
  // register bus: one wait cycle, then the access completes
  always_comb begin
    access = i_avs_read | i_avs_write;
    wait_next = !(access && wait_reg);
    do_write = i_avs_write && !wait_reg;
    frq_top = range_reg ? DLWB_FRQ_MAX_HIGH_RANGE : DLWB_FRQ_MAX_LOW_RANGE;
    range_next = range_reg;
    cur_lo_next = cur_lo_reg;
    cur_hi_next = cur_hi_reg;
    cur_max_next = cur_max_reg;
    frq_lo_next = frq_lo_reg;
    frq_hi_next = umin16(frq_hi_reg, frq_top);
    fb_lo_next = fb_lo_reg;
    fb_hi_next = fb_hi_reg;
    skip_bw_next = skip_bw_reg;
    skip_one_next = skip_one_reg;
    skip_two_next = skip_two_reg;
    route_sig_next = route_sig_reg;
    route_rel_next = route_rel_reg;
    irq_en_next = irq_en_reg;
    wv = 32'h0000_0000;
    fb_w = 32'sh0000_0000;
    if (do_write) begin
      case (i_avs_address)
        DLWB_OFS_CTRL: begin
          wv = be_merge({31'h0000_0000, range_reg}, i_avs_writedata, i_avs_byteenable);
          range_next = wv[DLWB_CTRL_RANGE_BIT];
        end
        DLWB_OFS_CUR_LO: begin
          wv = be_merge({16'h0000, cur_lo_reg}, i_avs_writedata, i_avs_byteenable);
          cur_lo_next = umin16(wv[15:0], cur_hi_reg);
        end
        DLWB_OFS_CUR_HI: begin
          wv = be_merge({16'h0000, cur_hi_reg}, i_avs_writedata, i_avs_byteenable);
          cur_hi_next = umin16(wv[15:0], cur_max_reg);
          cur_lo_next = umin16(cur_lo_reg, cur_hi_next);
        end
        DLWB_OFS_CUR_MAX: begin
          wv = be_merge({16'h0000, cur_max_reg}, i_avs_writedata, i_avs_byteenable);
          cur_max_next = wv[15:0];
          cur_hi_next = umin16(cur_hi_reg, cur_max_next);
          cur_lo_next = umin16(cur_lo_reg, cur_hi_next);
        end
        DLWB_OFS_FRQ_LO: begin
          wv = be_merge({16'h0000, frq_lo_reg}, i_avs_writedata, i_avs_byteenable);
          frq_lo_next = umin16(wv[15:0], frq_hi_reg);
        end
        DLWB_OFS_FRQ_HI: begin
          wv = be_merge({16'h0000, frq_hi_reg}, i_avs_writedata, i_avs_byteenable);
          // a high limit below the low limit is lifted to it rather than refused
          frq_hi_next = umin16(frq_top, (wv[15:0] < frq_lo_reg) ? frq_lo_reg : wv[15:0]);
        end
        DLWB_OFS_FB_LO: begin
          fb_w = be_merge(fb_lo_reg, i_avs_writedata, i_avs_byteenable);
          fb_lo_next = smin32((fb_w < DLWB_FB_FLOOR) ? DLWB_FB_FLOOR : fb_w, fb_hi_reg);
        end
        DLWB_OFS_FB_HI: begin
          fb_w = be_merge(fb_hi_reg, i_avs_writedata, i_avs_byteenable);
          fb_hi_next = smin32((fb_w < fb_lo_reg) ? fb_lo_reg : fb_w, DLWB_FB_CEIL);
        end
        DLWB_OFS_SKIP_BW: begin
          wv = be_merge({16'h0000, skip_bw_reg}, i_avs_writedata, i_avs_byteenable);
          skip_bw_next = umin16(wv[15:0], DLWB_SKIP_BW_MAX);
        end
        DLWB_OFS_SKIP_ONE: begin
          wv = be_merge({16'h0000, skip_one_reg}, i_avs_writedata, i_avs_byteenable);
          skip_one_next = umin16(wv[15:0], DLWB_SKIP_PT_MAX);
        end
        DLWB_OFS_SKIP_TWO: begin
          wv = be_merge({16'h0000, skip_two_reg}, i_avs_writedata, i_avs_byteenable);
          skip_two_next = umin16(wv[15:0], DLWB_SKIP_PT_MAX);
        end
        DLWB_OFS_ROUTE_SIG: begin
          wv = be_merge({26'h000_0000, route_sig_reg}, i_avs_writedata, i_avs_byteenable);
          route_sig_next = wv[5:0];
        end
        DLWB_OFS_ROUTE_REL: begin
          wv = be_merge({26'h000_0000, route_rel_reg}, i_avs_writedata, i_avs_byteenable);
          route_rel_next = wv[5:0];
        end
        DLWB_OFS_IRQ_EN: begin
          wv = be_merge({26'h000_0000, irq_en_reg}, i_avs_writedata, i_avs_byteenable);
          irq_en_next = wv[5:0];
        end
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data is latched on the first cycle so it stands at the completing edge
  always_comb begin
    rdata_next = rdata_reg;
    if (i_avs_read && wait_reg) begin
      case (i_avs_address)
        DLWB_OFS_CTRL: rdata_next = {31'h0000_0000, range_reg};
        DLWB_OFS_CUR_LO: rdata_next = {16'h0000, cur_lo_reg};
        DLWB_OFS_CUR_HI: rdata_next = {16'h0000, cur_hi_reg};
        DLWB_OFS_CUR_MAX: rdata_next = {16'h0000, cur_max_reg};
        DLWB_OFS_FRQ_LO: rdata_next = {16'h0000, frq_lo_reg};
        DLWB_OFS_FRQ_HI: rdata_next = {16'h0000, frq_hi_reg};
        DLWB_OFS_FB_LO: rdata_next = fb_lo_reg;
        DLWB_OFS_FB_HI: rdata_next = fb_hi_reg;
        DLWB_OFS_SKIP_BW: rdata_next = {16'h0000, skip_bw_reg};
        DLWB_OFS_SKIP_ONE: rdata_next = {16'h0000, skip_one_reg};
        DLWB_OFS_SKIP_TWO: rdata_next = {16'h0000, skip_two_reg};
        DLWB_OFS_ROUTE_SIG: rdata_next = {26'h000_0000, route_sig_reg};
        DLWB_OFS_ROUTE_REL: rdata_next = {26'h000_0000, route_rel_reg};
        DLWB_OFS_WARN: rdata_next = {25'h000_0000, (state_reg == DLWB_ST_ACTIVE), warn_reg};
        DLWB_OFS_IRQ_STAT: rdata_next = {26'h000_0000, irq_stat_reg};
        DLWB_OFS_IRQ_EN: rdata_next = {26'h000_0000, irq_en_reg};
        DLWB_OFS_REF_ADJ: rdata_next = {16'h0000, ref_adj_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      range_reg <= 1'b0;
      cur_lo_reg <= DLWB_RST_CUR_LO;
      cur_hi_reg <= DLWB_RST_CUR_MAX;
      cur_max_reg <= DLWB_RST_CUR_MAX;
      frq_lo_reg <= DLWB_RST_FRQ_LO;
      frq_hi_reg <= DLWB_RST_FRQ_HI;
      fb_lo_reg <= DLWB_RST_FB_LO;
      fb_hi_reg <= DLWB_RST_FB_HI;
      skip_bw_reg <= DLWB_RST_SKIP;
      skip_one_reg <= DLWB_RST_SKIP;
      skip_two_reg <= DLWB_RST_SKIP;
      route_sig_reg <= DLWB_RST_ROUTE;
      route_rel_reg <= DLWB_RST_ROUTE;
      irq_en_reg <= DLWB_RST_ROUTE;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      range_reg <= range_next;
      cur_lo_reg <= cur_lo_next;
      cur_hi_reg <= cur_hi_next;
      cur_max_reg <= cur_max_next;
      frq_lo_reg <= frq_lo_next;
      frq_hi_reg <= frq_hi_next;
      fb_lo_reg <= fb_lo_next;
      fb_hi_reg <= fb_hi_next;
      skip_bw_reg <= skip_bw_next;
      skip_one_reg <= skip_one_next;
      skip_two_reg <= skip_two_next;
      route_sig_reg <= route_sig_next;
      route_rel_reg <= route_rel_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // ==========================================================================
  // start/stop supervision and warning outputs
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DLWB_ST_STOPPED: begin
        if (i_run && !run_d_reg) begin
          state_next = DLWB_ST_RAMPING;
        end
      end
      DLWB_ST_RAMPING: begin
        if (!i_run) begin
          state_next = DLWB_ST_STOPPED;
        end else if (i_out_freq == ref_adj_reg) begin
          state_next = DLWB_ST_ACTIVE;
        end
      end
      DLWB_ST_ACTIVE: begin
        if (!i_run) begin
          state_next = DLWB_ST_STOPPED;
        end
      end
      default: state_next = DLWB_ST_STOPPED;
    endcase
    warn_next = (state_reg == DLWB_ST_ACTIVE) ? cmp_raw : 6'h00;
    sig_next = |(warn_reg & route_sig_reg);
    rel_next = |(warn_reg & route_rel_reg);
    // a new warning edge in the clearing cycle survives the clear
    irq_stat_next = irq_stat_reg;
    if (do_write && (i_avs_address == DLWB_OFS_IRQ_CLR)) begin
      irq_stat_next = irq_stat_reg & ~(i_avs_writedata[5:0] & {6{i_avs_byteenable[0]}});
    end
    irq_stat_next = irq_stat_next | (warn_reg & ~warn_d_reg);
    irq_next = |(irq_stat_reg & irq_en_reg);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= DLWB_ST_STOPPED;
      run_d_reg <= 1'b0;
      warn_reg <= 6'h00;
      warn_d_reg <= 6'h00;
      sig_reg <= 1'b0;
      rel_reg <= 1'b0;
      irq_stat_reg <= 6'h00;
      irq_reg <= 1'b0;
      ref_adj_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      run_d_reg <= i_run;
      warn_reg <= warn_next;
      warn_d_reg <= warn_reg;
      sig_reg <= sig_next;
      rel_reg <= rel_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
      ref_adj_reg <= ref_fin;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_ref_adjusted = ref_adj_reg;
  assign o_signal_warn = sig_reg;
  assign o_relay_warn = rel_reg;
  assign o_irq = irq_reg;
endmodule : dlwb_top
`default_nettype wire

/* test/dlwb_power_stage.sv */
// model: power stage that ramps output frequency to the adjusted reference
`timescale 1ns/1ps
`default_nettype none
module dlwb_power_stage #(
  parameter logic [15:0] STEP = 16'h0010
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // command and reference
  input wire logic i_run,
  input wire logic [15:0] i_ref,
  // measured output frequency
  output logic [15:0] o_freq
);
  // ==========
  // coasts to zero at once on stop, the harshest case for the blocking logic
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      o_freq <= 16'h0000;
    end else if ({1'b0, o_freq} + {1'b0, STEP} < {1'b0, i_ref}) begin
      o_freq <= o_freq + STEP;
    end else begin
      o_freq <= i_ref;
    end
  end
endmodule : dlwb_power_stage
`default_nettype wire

/* test/dlwb_top_asserts.sv */
// checker: port-level assertions of the limit warning and bypass block
`timescale 1ns/1ps
`default_nettype none
module dlwb_top_asserts
  import dlwb_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // drive
  input wire logic i_run,
  input wire logic o_signal_warn,
  input wire logic o_relay_warn
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========
  sequence s_idle3; !i_run [*3]; endsequence
  sequence s_start; s_idle3 ##1 i_run; endsequence
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  property p_wait_idle; !i_avs_read && !i_avs_write |=> o_avs_waitrequest; endproperty
  property p_rd_zero;
    i_avs_read && o_avs_waitrequest && (i_avs_address == DLWB_OFS_IRQ_CLR || i_avs_address == 8'hFC)
      |=> o_avs_readdata == 32'h0000_0000;
  endproperty
  property p_rd_hold; !i_avs_read |=> $stable(o_avs_readdata); endproperty
  property p_stop_quiet; s_idle3 |=> !o_signal_warn && !o_relay_warn; endproperty
  property p_start_quiet; s_start |-> (!o_signal_warn && !o_relay_warn) [*4]; endproperty
  property p_relay_stop; $fell(i_run) |-> ##[1:3] !o_relay_warn; endproperty
  property p_warn_cause; $rose(o_signal_warn) |-> $past(i_run, 3) && $past(i_run, 4); endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  a_wait_idle: assert property (p_wait_idle) else $error("wait low without request");
  a_rd_zero: assert property (p_rd_zero) else $error("nonzero read");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_stop_quiet: assert property (p_stop_quiet) else $error("warning while stopped");
  a_start_quiet: assert property (p_start_quiet) else $error("warning in ramp");
  a_relay_stop: assert property (p_relay_stop) else $error("relay after stop");
  a_warn_cause: assert property (p_warn_cause) else $error("warning not running");
endmodule : dlwb_top_asserts
bind dlwb_top dlwb_top_asserts chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_run(i_run), .o_signal_warn(o_signal_warn),
  .o_relay_warn(o_relay_warn));
`default_nettype wire

/* test/tb_drive_limit_warning_bypass.sv */
// testbench: limit warnings, blocking, routing, interrupts and skip bands
`timescale 1ns/1ps
`default_nettype none
module tb_drive_limit_warning_bypass;
  import dlwb_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_signal_warn, o_relay_warn, o_irq, i_run = 1'b0;
  logic [15:0] i_out_current = 16'h0000;
  logic [15:0] i_ref_freq = 16'h0000;
  logic [15:0] i_out_freq, o_ref_adjusted;
  logic signed [31:0] i_feedback = 32'h0000_0000;
  int error_cnt = 0;
  int checks = 0;
  always #25 i_clk = ~i_clk;
  dlwb_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_run(i_run),
    .i_out_current(i_out_current), .i_out_freq(i_out_freq), .i_feedback(i_feedback), .i_ref_freq(i_ref_freq),
    .o_ref_adjusted(o_ref_adjusted), .o_signal_warn(o_signal_warn), .o_relay_warn(o_relay_warn), .o_irq(o_irq));
  dlwb_power_stage #(.STEP(16'h0010)) stage_u (.i_clk(i_clk), .i_rst(i_rst), .i_run(i_run),
    .i_ref(o_ref_adjusted), .o_freq(i_out_freq));
  // ==========
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0) begin
      @(posedge i_clk);
    end
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    cmp(what, exp, q);
  endtask : rd
  // signal route takes all six, relay only the high current bit
  task automatic check_warn(input string what, input logic [5:0] bits);
    repeat (4) @(posedge i_clk);
    rd(what, DLWB_OFS_WARN, {25'h0, 1'b1, bits});
    cmp("signal out", {31'h0, |bits}, {31'h0, o_signal_warn});
    cmp("relay out", {31'h0, bits[1]}, {31'h0, o_relay_warn});
  endtask : check_warn
  task automatic skip_chk(input logic [15:0] r, input logic [15:0] exp);
    i_ref_freq <= r;
    repeat (3) @(posedge i_clk);
    cmp("ref adj", {16'h0, exp}, {16'h0, o_ref_adjusted});
  endtask : skip_chk
  // ==========
  task automatic t_reset_values();
    rd("cur lo", DLWB_OFS_CUR_LO, 32'h0000_0000);
    rd("frq lo", DLWB_OFS_FRQ_LO, 32'h0000_0000);
    rd("frq hi", DLWB_OFS_FRQ_HI, 32'h0000_0528);
    rd("fb lo", DLWB_OFS_FB_LO, 32'hFFC2_F700);
    rd("fb hi", DLWB_OFS_FB_HI, 32'h003D_0900);
    rd("bw", DLWB_OFS_SKIP_BW, 32'h0000_0000);
    rd("unmapped", 8'hFC, 32'h0000_0000);
  endtask : t_reset_values
  task automatic t_clamps();
    wr(DLWB_OFS_CUR_LO, 32'h0000_0FFF);
    rd("cur lo clamp", DLWB_OFS_CUR_LO, 32'h0000_00A0);
    wr(DLWB_OFS_CUR_HI, 32'h0000_FFFF);
    rd("cur hi clamp", DLWB_OFS_CUR_HI, 32'h0000_00A0);
    wr(DLWB_OFS_FB_LO, 32'h8000_0000);
    rd("fb floor", DLWB_OFS_FB_LO, 32'hFA0A_1F00);
    wr(DLWB_OFS_FB_LO, 32'h7FFF_FFFF);
    rd("fb lo le hi", DLWB_OFS_FB_LO, 32'h003D_0900);
    wr(DLWB_OFS_FB_LO, 32'hFFC2_F700);
    wr(DLWB_OFS_FRQ_HI, 32'h0000_2710);
    rd("frq hi 132", DLWB_OFS_FRQ_HI, 32'h0000_0528);
    wr(DLWB_OFS_CTRL, 32'h0000_0001);
    wr(DLWB_OFS_FRQ_HI, 32'h0000_2710);
    rd("frq hi 1000", DLWB_OFS_FRQ_HI, 32'h0000_2710);
    wr(DLWB_OFS_CTRL, 32'h0000_0000);
    rd("frq hi pull", DLWB_OFS_FRQ_HI, 32'h0000_0528);
    wr(DLWB_OFS_FRQ_LO, 32'h0000_FFFF);
    rd("frq lo clamp", DLWB_OFS_FRQ_LO, 32'h0000_0528);
    wr(DLWB_OFS_FRQ_LO, 32'h0000_0000);
    wr(DLWB_OFS_SKIP_BW, 32'h0000_FFFF);
    rd("bw clamp", DLWB_OFS_SKIP_BW, 32'h0000_03E8);
    wr(DLWB_OFS_SKIP_TWO, 32'h0000_FFFF);
    rd("pt clamp", DLWB_OFS_SKIP_TWO, 32'h0000_2710);
    wr(DLWB_OFS_SKIP_BW, 32'h0000_0000);
    wr(DLWB_OFS_SKIP_TWO, 32'h0000_0000);
  endtask : t_clamps
  task automatic t_warnings();
    logic [31:0] q;
    q = 32'h0000_0000;
    wr(DLWB_OFS_CUR_LO, 32'h0000_0050);
    wr(DLWB_OFS_ROUTE_SIG, 32'h0000_003F);
    wr(DLWB_OFS_ROUTE_REL, 32'h0000_0002);
    wr(DLWB_OFS_IRQ_EN, 32'h0000_0001);
    i_ref_freq <= 16'h01F4;
    i_out_current <= 16'h0010;
    i_run <= 1'b1;
    repeat (8) @(posedge i_clk);
    cmp("ramp quiet", 32'h0000_0000, {31'h0, o_signal_warn});
    for (int n = 0; n < 40 && q[6] !== 1'b1; n++) bus(1'b0, DLWB_OFS_WARN, 32'h0000_0000, q);
    cmp("freq reached", 32'h0000_01F4, {16'h0, i_out_freq});
    check_warn("cur low", 6'h01);
    rd("irq stat", DLWB_OFS_IRQ_STAT, 32'h0000_0001);
    cmp("irq", 32'h0000_0001, {31'h0, o_irq});
    i_out_current <= 16'h00A0;
    check_warn("cur at hi", 6'h00);
    wr(DLWB_OFS_IRQ_CLR, 32'h0000_003F);
    i_out_current <= 16'h00A1;
    check_warn("cur hi", 6'h02);
    rd("irq stat masked", DLWB_OFS_IRQ_STAT, 32'h0000_0002);
    cmp("irq masked", 32'h0000_0000, {31'h0, o_irq});
    i_out_current <= 16'h0060;
    i_feedback <= 32'hFFC2_F6FF;
    check_warn("fb low", 6'h10);
    i_feedback <= 32'h003D_0901;
    check_warn("fb high", 6'h20);
    i_feedback <= 32'h0000_0000;
    wr(DLWB_OFS_FRQ_LO, 32'h0000_01F5);
    check_warn("frq low", 6'h04);
    wr(DLWB_OFS_FRQ_LO, 32'h0000_0000);
    wr(DLWB_OFS_FRQ_HI, 32'h0000_01F3);
    check_warn("frq high", 6'h08);
    i_out_current <= 16'h0010;
    i_run <= 1'b0;
    repeat (4) @(posedge i_clk);
    cmp("stop quiet", 32'h0000_0000, {31'h0, o_signal_warn});
    rd("warn stopped", DLWB_OFS_WARN, 32'h0000_0000);
  endtask : t_warnings
  task automatic t_skip();
    wr(DLWB_OFS_SKIP_BW, 32'h0000_0064);
    wr(DLWB_OFS_SKIP_ONE, 32'h0000_01F4);
    skip_chk(16'h01F0, 16'h01C2);
    skip_chk(16'h01F8, 16'h0226);
    skip_chk(16'h01C2, 16'h01C2);
    wr(DLWB_OFS_SKIP_TWO, 32'h0000_0300);
    skip_chk(16'h0310, 16'h0332);
    rd("ref reg", DLWB_OFS_REF_ADJ, 32'h0000_0332);
    wr(DLWB_OFS_SKIP_BW, 32'h0000_0000);
    skip_chk(16'h01F0, 16'h01F0);
  endtask : t_skip
  // ==========
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset_values();
    t_clamps();
    t_warnings();
    t_skip();
    report_and_stop();
  end
  // run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_drive_limit_warning_bypass
`default_nettype wire
